// [design/atamc_pkg.sv]
// Constants shared by the alert and mode control block.
// Assumes a 100 MHz system clock and 16-bit register words.
package atamc_pkg;
    localparam int unsigned CLK_MHZ        = 100;
    localparam int unsigned CLK_HZ_DEF     = 100_000_000;
    localparam int unsigned RDY_PULSE_NS   = 8000;
    localparam int unsigned RDY_PULSE_CYC  = (RDY_PULSE_NS * CLK_MHZ) / 1000;
    localparam int unsigned RATE_SPS [8]   = '{64, 128, 256, 512, 1024, 2000, 4000, 8000};

    localparam logic [2:0] ADDR_CONV   = 3'h0;
    localparam logic [2:0] ADDR_CFG    = 3'h1;
    localparam logic [2:0] ADDR_LOWER  = 3'h2;
    localparam logic [2:0] ADDR_UPPER  = 3'h3;
    localparam logic [2:0] ADDR_STATUS = 3'h4;

    localparam int unsigned CFG_ONE_SHOT = 15;
    localparam int unsigned CFG_MODE     = 8;
    localparam int unsigned CFG_RATE_LSB = 5;
    localparam int unsigned CFG_CMODE    = 4;
    localparam int unsigned CFG_POL      = 3;
    localparam int unsigned CFG_LATCH    = 2;
    localparam int unsigned CFG_QUE_LSB  = 0;

    localparam int unsigned ST_BUSY  = 3;
    localparam int unsigned ST_ALERT = 2;
    localparam int unsigned ST_TRIP  = 1;
    localparam int unsigned ST_LINE  = 0;

    localparam logic        MODE_RST   = 1'b1;
    localparam logic [2:0]  RATE_RST   = 3'h4;
    localparam logic [1:0]  QUE_RST    = 2'h3;
    localparam logic [1:0]  QUE_OFF    = 2'h3;
    localparam logic [15:0] UPPER_RST  = 16'h7FFF;
    localparam logic [15:0] LOWER_RST  = 16'h8000;
    localparam logic [7:0]  GC_RESET   = 8'h06;
    localparam logic [7:0]  ARA_ADDR   = 8'h19;

    typedef enum logic [1:0] {
        ATAMC_IDLE = 2'b01,
        ATAMC_RUN  = 2'b10
    } atamc_state_e;
endpackage

// [design/atamc_ctrl.sv]
// Threshold alert, conversion-ready and conversion sequencing control.
// Assumes core_data comes from converter logic on clk; alert line pulled up outside.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
module atamc_ctrl
    import atamc_pkg::*;
#(
    parameter int unsigned CLK_HZ = CLK_HZ_DEF
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [2:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic [15:0] core_data,
    output logic             core_run,
    input  wire logic        gc_cmd_valid,
    input  wire logic [7:0]  gc_cmd_byte,
    input  wire logic        addr_valid,
    input  wire logic [7:0]  addr_byte,
    input  wire logic        ara_won,
    output logic             ara_reply,
    output logic             ara_status,
    input  wire logic        alert_in,
    output logic             alert_out,
    output logic             alert_oe
);

    typedef struct packed {
        atamc_state_e state;
        logic [31:0]  cnt;
        logic [15:0]  pulse_cnt;
        logic [15:0]  conv;
        logic [15:0]  upper;
        logic [15:0]  lower;
        logic         mode;
        logic [2:0]   rate;
        logic         cmode;
        logic         pol;
        logic         latch;
        logic [1:0]   que;
        logic [2:0]   hits;
        logic         alert;
        logic         trip_high;
        logic         reply;
        logic         line_s1;
        logic         line_s2;
        logic [15:0]  rdata;
    } atamc_regs_s;

    localparam atamc_regs_s RST = '{
        state:     ATAMC_IDLE,
        cnt:       32'h0000_0000,
        pulse_cnt: 16'h0000,
        conv:      16'h0000,
        upper:     UPPER_RST,
        lower:     LOWER_RST,
        mode:      MODE_RST,
        rate:      RATE_RST,
        cmode:     1'b0,
        pol:       1'b0,
        latch:     1'b0,
        que:       QUE_RST,
        hits:      3'h0,
        alert:     1'b0,
        trip_high: 1'b0,
        reply:     1'b0,
        line_s1:   1'b1,
        line_s2:   1'b1,
        rdata:     16'h0000
    };

    atamc_regs_s r_ff;
    atamc_regs_s nxt_r;

    logic [31:0] period_tab [8];

    // Cycles per conversion for each rate
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_rate
            assign period_tab[gi] = 32'(CLK_HZ / RATE_SPS[gi]);
        end
    endgenerate

    logic        done;
    logic        above;
    logic        below;
    logic        outside;
    logic [2:0]  need;
    logic        rdy_mode;
    logic        rdy_act;
    logic        active;
    logic        level;
    logic        cfg_wr;
    logic        conv_rd;
    logic [15:0] cfg_view;

    always_comb begin
        done     = (r_ff.state == ATAMC_RUN) && (r_ff.cnt >= period_tab[r_ff.rate] - 32'd1);
        above    = $signed(core_data) > $signed(r_ff.upper);
        below    = $signed(core_data) < $signed(r_ff.lower);
        // Traditional counts only upper trips toward assertion
        outside  = r_ff.cmode ? (above | below) : above;
        case (r_ff.que)
            2'h0:    need = 3'h1;
            2'h1:    need = 3'h2;
            2'h2:    need = 3'h4;
            default: need = 3'h7;
        endcase
        rdy_mode = r_ff.upper[15] & ~r_ff.lower[15];
        // Continuous: pulse after each result; single-shot: active while converting
        rdy_act  = r_ff.mode ? (r_ff.state == ATAMC_RUN) : (r_ff.pulse_cnt != 16'h0000);
        active   = rdy_mode ? rdy_act : r_ff.alert;
        level    = r_ff.pol ? active : ~active;
        if (r_ff.que == QUE_OFF) begin
            level = 1'b1;
        end
        cfg_wr   = reg_wr && (reg_addr == ADDR_CFG);
        conv_rd  = reg_rd && (reg_addr == ADDR_CONV);
        cfg_view = 16'h0000;
        cfg_view[CFG_ONE_SHOT] = (r_ff.state == ATAMC_IDLE);
        cfg_view[CFG_MODE] = r_ff.mode;
        cfg_view[CFG_RATE_LSB +: 3] = r_ff.rate;
        cfg_view[CFG_CMODE] = r_ff.cmode;
        cfg_view[CFG_POL] = r_ff.pol;
        cfg_view[CFG_LATCH] = r_ff.latch;
        cfg_view[CFG_QUE_LSB +: 2] = r_ff.que;
    end

    always_comb begin
        nxt_r = r_ff;
        nxt_r.line_s1 = alert_in;
        nxt_r.line_s2 = r_ff.line_s1;
        nxt_r.reply = addr_valid && (addr_byte == ARA_ADDR) && r_ff.alert;

        // Register reads
        case (reg_addr)
            ADDR_CONV:   nxt_r.rdata = r_ff.conv;
            ADDR_CFG:    nxt_r.rdata = cfg_view;
            ADDR_LOWER:  nxt_r.rdata = r_ff.lower;
            ADDR_UPPER:  nxt_r.rdata = r_ff.upper;
            ADDR_STATUS: nxt_r.rdata = {12'h000, (r_ff.state == ATAMC_RUN), r_ff.alert,
                                        r_ff.trip_high, r_ff.line_s2};
            default:     nxt_r.rdata = 16'h0000;
        endcase
        if (!reg_rd) begin
            nxt_r.rdata = 16'h0000;
        end

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                ADDR_CFG: begin
                    nxt_r.mode  = reg_wdata[CFG_MODE];
                    nxt_r.rate  = reg_wdata[CFG_RATE_LSB +: 3];
                    nxt_r.cmode = reg_wdata[CFG_CMODE];
                    nxt_r.pol   = reg_wdata[CFG_POL];
                    nxt_r.latch = reg_wdata[CFG_LATCH];
                    nxt_r.que   = reg_wdata[CFG_QUE_LSB +: 2];
                end
                ADDR_LOWER: nxt_r.lower = reg_wdata;
                ADDR_UPPER: nxt_r.upper = reg_wdata;
                default: nxt_r.rdata = nxt_r.rdata;
            endcase
        end

        // Ready pulse timer
        if (r_ff.pulse_cnt != 16'h0000) begin
            nxt_r.pulse_cnt = r_ff.pulse_cnt - 16'h0001;
        end

        // Clearing the alert; a trip below wins
        if (conv_rd || (ara_won && r_ff.alert)) begin
            nxt_r.alert = 1'b0;
        end

        // Conversion sequencing
        case (r_ff.state)
            ATAMC_IDLE: begin
                nxt_r.cnt = 32'h0000_0000;
                if (!r_ff.mode || (cfg_wr && reg_wdata[CFG_ONE_SHOT])) begin
                    nxt_r.state = ATAMC_RUN;
                end
            end
            ATAMC_RUN: begin
                // One-shot writes here find no effect
                nxt_r.cnt = r_ff.cnt + 32'd1;
                if (done) begin
                    nxt_r.cnt  = 32'h0000_0000;
                    nxt_r.conv = core_data;
                    nxt_r.state = r_ff.mode ? ATAMC_IDLE : ATAMC_RUN;
                    if (!r_ff.mode) begin
                        nxt_r.pulse_cnt = 16'(RDY_PULSE_CYC);
                    end
                    // Comparator runs on each finished result
                    if (outside) begin
                        nxt_r.hits = (r_ff.hits < need) ? r_ff.hits + 3'h1 : r_ff.hits;
                    end else begin
                        nxt_r.hits = 3'h0;
                    end
                    if (r_ff.que != QUE_OFF && outside && r_ff.hits + 3'h1 >= need) begin
                        nxt_r.alert = 1'b1;
                        nxt_r.trip_high = r_ff.cmode ? above : 1'b1;
                    end else if (!r_ff.latch && r_ff.alert) begin
                        if (r_ff.cmode ? !(above | below) : below) begin
                            nxt_r.alert = 1'b0;
                        end
                    end
                end
            end
            default: nxt_r.state = ATAMC_IDLE;
        endcase

        if (r_ff.que == QUE_OFF) begin
            nxt_r.alert = 1'b0;
            nxt_r.hits  = 3'h0;
        end

        // General call reset acts like power-up
        if (gc_cmd_valid && gc_cmd_byte == GC_RESET) begin
            nxt_r = RST;
            nxt_r.line_s1 = alert_in;
            nxt_r.line_s2 = r_ff.line_s1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            r_ff <= RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign reg_rdata  = r_ff.rdata;
    assign core_run   = (r_ff.state == ATAMC_RUN);
    assign ara_reply  = r_ff.reply;
    assign ara_status = r_ff.trip_high;
    assign alert_out  = 1'b0;
    assign alert_oe   = ~level;

endmodule

// [testbench/atamc_ctrl_monitor.sv]
// Checker for the alert and mode control block, bound to its ports.
// Assumes the design clock and its active-high asynchronous reset.
`timescale 1ns/1ps
module atamc_ctrl_monitor
    import atamc_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [2:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        core_run,
    input wire logic        gc_cmd_valid,
    input wire logic [7:0]  gc_cmd_byte,
    input wire logic        addr_valid,
    input wire logic [7:0]  addr_byte,
    input wire logic        ara_reply,
    input wire logic        alert_out,
    input wire logic        alert_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_open_drain; alert_out == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unmapped; reg_rd && reg_addr > ADDR_STATUS |=> reg_rdata == 16'h0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read data");
    property p_one_shot;
        reg_wr && reg_addr == ADDR_CFG && reg_wdata[15] && reg_wdata[8] && !core_run |=> core_run;
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("one-shot did not start");
    property p_gc;
        gc_cmd_valid && gc_cmd_byte == GC_RESET |=> !core_run && !alert_oe && !ara_reply;
    endproperty
    a_gc: assert property (p_gc) else $error("general call left state");
    property p_reply; ara_reply |-> $past(addr_valid) && $past(addr_byte) == ARA_ADDR; endproperty
    a_reply: assert property (p_reply) else $error("reply without response address");
    property p_no_reply; addr_valid && addr_byte != ARA_ADDR |=> !ara_reply; endproperty
    a_no_reply: assert property (p_no_reply) else $error("reply to other address");
    property p_run_min; $rose(core_run) |-> core_run [*8]; endproperty
    a_run_min: assert property (p_run_min) else $error("conversion too short");
    c_reply: cover property (ara_reply);
    c_done: cover property ($fell(core_run));
    c_pulse: cover property ($rose(alert_oe) && core_run);
endmodule
bind atamc_ctrl atamc_ctrl_monitor u_atamc_ctrl_monitor (.*);

// [testbench/atamc_host_model.sv]
// Host model: alert responses, general calls and the pulled-up alert line.
// Assumes the device only pulls the line low through alert_oe.
`timescale 1ns/1ps
module atamc_host_model
    import atamc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       alert_oe,
    input  wire logic       ara_reply,
    output logic            alert_line,
    output logic            addr_valid,
    output logic      [7:0] addr_byte,
    output logic            gc_cmd_valid,
    output logic      [7:0] gc_cmd_byte,
    output logic            ara_won
);
    int replies = 0;
    assign alert_line = alert_oe ? 1'b0 : 1'b1;
    initial begin
        {addr_valid, gc_cmd_valid, ara_won, addr_byte, gc_cmd_byte} = 19'h0;
    end
    task automatic send(input logic [7:0] b);
        @(posedge clk);
        addr_valid <= 1'b1;
        addr_byte  <= b;
        @(posedge clk);
        addr_valid <= 1'b0;
        addr_byte  <= ~b;
        #1;
        if (ara_reply === 1'b1) replies++;
    endtask
    // Response address sent up to three times while the line stays low
    task automatic ara(input logic win);
        for (int i = 0; i < 3 && alert_line === 1'b0; i++) begin
            send(ARA_ADDR);
            if (ara_reply === 1'b1 && win) begin
                @(posedge clk);
                ara_won <= 1'b1;
                @(posedge clk);
                ara_won <= 1'b0;
            end
            @(posedge clk);
        end
    endtask
    task automatic gc(input logic [7:0] b);
        @(posedge clk);
        gc_cmd_valid <= 1'b1;
        gc_cmd_byte  <= b;
        @(posedge clk);
        gc_cmd_valid <= 1'b0;
        gc_cmd_byte  <= ~b;
    endtask
endmodule

// [testbench/test_atamc_ctrl.sv]
// Bench: registers, comparator, alert response and ready use against a host model.
// Assumes CLK_HZ shortened so rate 7 gives 1000 cycles per conversion.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module test_atamc_ctrl
    import atamc_pkg::*;
;
    localparam int P = 1000;
    logic        clk, reset, reg_wr, reg_rd, core_run, gc_cmd_valid, addr_valid, ara_won;
    logic        ara_reply, ara_status, alert_in, alert_out, alert_oe;
    logic [2:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, core_data;
    logic [7:0]  gc_cmd_byte, addr_byte;
    int          fail_count, comparisons, n;
    atamc_ctrl #(.CLK_HZ(8_000_000)) u_atamc_ctrl (.*);
    atamc_host_model u_atamc_host_model (.*, .alert_line(alert_in));
    initial begin clk = 1'b0; forever #5 clk = ~clk; end
    initial begin #1_000_000; fail_count++; close_out(); end
    task automatic close_out();
        if (fail_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk);
        {reg_wr, reg_wdata} <= {1'b0, ~d};
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 `CHK("read", e, reg_rdata)
    endtask
    // One single-shot conversion; again rewrites the start bit mid-run
    task automatic go(input logic [15:0] cfg, input logic [15:0] d, input logic again);
        int k;
        @(posedge clk);
        core_data <= d;
        wr(ADDR_CFG, cfg);
        #1 `CHK("run", 1'b1, core_run)
        k = 0;
        if (again) begin wr(ADDR_CFG, cfg); #1 k = 2; end
        while (core_run === 1'b1 && k < 2 * P) begin @(posedge clk); #1 k++; end
        `CHK("period", P, k)
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic t_defaults();
        rd(ADDR_CFG, 16'h8183);
        rd(ADDR_UPPER, UPPER_RST);
        rd(ADDR_LOWER, LOWER_RST);
        rd(3'h7, 16'h0000);
        `CHK("idle", 1'b0, core_run)
        `CHK("drain", 1'b0, alert_out)
        wr(ADDR_UPPER, 16'h0064);
        u_atamc_host_model.gc(GC_RESET);
        rd(ADDR_UPPER, UPPER_RST);
    endtask
    task automatic t_comp();
        wr(ADDR_UPPER, 16'h0064);
        wr(ADDR_LOWER, 16'h0000);
        for (int q = 0; q < 3; q++) begin
            for (int h = 1; h <= (1 << q); h++) begin
                go({14'h2078, q[1:0]}, 16'h00C8, 1'b0);
                `CHK("hits", h == (1 << q), alert_oe)
            end
            go({14'h2078, q[1:0]}, 16'h0032, 1'b0);
            `CHK("hold", 1'b1, alert_oe)
            go({14'h2078, q[1:0]}, 16'hFFF6, 1'b0);
            `CHK("release", 1'b0, alert_oe)
        end
        go(16'h81E3, 16'h00C8, 1'b0);
        `CHK("disabled", 1'b0, alert_oe)
        go(16'h81E8, 16'hFFF6, 1'b0);
        `CHK("pol idle", 1'b1, alert_oe)
        go(16'h81E8, 16'h00C8, 1'b0);
        `CHK("pol active", 1'b0, alert_oe)
        go(16'h81E4, 16'h00C8, 1'b0);
        go(16'h81E4, 16'hFFF6, 1'b1);
        `CHK("latched", 1'b1, alert_oe)
        rd(ADDR_CONV, 16'hFFF6);
        `CHK("read clear", 1'b0, alert_oe)
    endtask
    task automatic t_ara();
        go(16'h81E4, 16'h00C8, 1'b0);
        `CHK("retrip", 1'b1, alert_oe)
        `CHK("dir high", 1'b1, ara_status)
        rd(ADDR_STATUS, 16'h0006);
        u_atamc_host_model.send(8'h91);
        `CHK("other", 1'b0, ara_reply)
        u_atamc_host_model.ara(1'b0);
        `CHK("loser", 1'b1, alert_oe)
        `CHK("replies", 3, u_atamc_host_model.replies)
        u_atamc_host_model.ara(1'b1);
        `CHK("winner", 1'b0, alert_oe)
        go(16'h81F4, 16'hFFF6, 1'b0);
        `CHK("window", 1'b1, alert_oe)
        `CHK("dir low", 1'b0, ara_status)
        u_atamc_host_model.ara(1'b1);
        `CHK("cleared", 1'b0, alert_oe)
    endtask
    task automatic t_ready();
        wr(ADDR_UPPER, 16'h8000);
        wr(ADDR_LOWER, 16'h0000);
        fork
            go(16'h81F4, 16'h0005, 1'b0);
            begin repeat (10) @(posedge clk); #1 `CHK("busy", 1'b1, alert_oe) end
        join
        `CHK("done high", 1'b0, alert_oe)
        wr(ADDR_CFG, 16'h00F4);
        n = 0;
        while (alert_oe !== 1'b1 && n < 2 * P) begin @(posedge clk); #1 n++; end
        n = 0;
        while (alert_oe === 1'b1 && n < 2 * P) begin @(posedge clk); #1 n++; end
        `CHK("pulse", RDY_PULSE_CYC, n)
        `CHK("next", 1'b1, core_run)
        wr(ADDR_CFG, 16'h01F4);
        n = 0;
        while (core_run === 1'b1 && n < 2 * P) begin @(posedge clk); #1 n++; end
        `CHK("stop", 1'b0, core_run)
    endtask
    initial begin
        {reset, reg_wr, reg_rd, reg_addr, reg_wdata, core_data} = 38'h2000000000;
        {fail_count, comparisons} = 64'h0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        t_defaults();
        t_comp();
        t_ara();
        t_ready();
        close_out();
    end
endmodule
